// ===== src/tpf_pkg.sv
// package for the table pointer flash self-programming block
package tpf_pkg;
   // wishbone word offsets
   localparam logic [3:0] ADR_PTR_LOW = 4'h0;
   localparam logic [3:0] ADR_PTR_HIGH = 4'h1;
   localparam logic [3:0] ADR_PTR_UPPER = 4'h2;
   localparam logic [3:0] ADR_LATCH = 4'h3;
   localparam logic [3:0] ADR_CONTROL = 4'h4;
   localparam logic [3:0] ADR_UNLOCK = 4'h5;
   localparam logic [3:0] ADR_TABLE_OP = 4'h6;
   // control register field positions
   localparam int CTL_START_BIT = 1;
   localparam int CTL_ENABLE_BIT = 2;
   localparam int CTL_FAULT_BIT = 3;
   localparam int CTL_ERASE_BIT = 4;
   // table op word fields: bit 0 write, bits 2:1 pointer action
   localparam int OP_WRITE_BIT = 0;
   localparam logic [1:0] ACT_KEEP = 2'h0;
   localparam logic [1:0] ACT_POST_INC = 2'h1;
   localparam logic [1:0] ACT_POST_DEC = 2'h2;
   localparam logic [1:0] ACT_PRE_INC = 2'h3;
   // unlock key bytes
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // geometry
   localparam int PTR_W = 22;
   localparam int HOLD_N = 64;
   localparam int BLOCK_ADR_LSB = 10;
   // reset values
   localparam logic [21:0] PTR_RST = 22'h000000;
   localparam logic [7:0] LATCH_RST = 8'h00;
   // timing: program and erase durations in microseconds at 10 MHz
   localparam int CLK_MHZ = 10;
   localparam int PROG_TIME_US = 1000;
   localparam int ERASE_TIME_US = 1000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   // controller states
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LONG, ST_DONE} tpf_state_t;
endpackage

// ===== src/tpf_mem.sv
// program flash model with registered read port and byte write port
`timescale 1ns/1ns
module tpf_mem (
   // clock
   input wire logic clk_i,
   // read port
   input wire logic [21:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   // write port, one byte per cycle
   input wire logic wr_en_i,
   input wire logic [21:0] wr_addr_i,
   input wire logic [7:0] wr_data_i
);
   localparam int MEM_BYTES = 8192;
   logic [7:0] mem [0:MEM_BYTES-1];
   logic [7:0] id_space [0:15];

   // constant identification space; values are arbitrary
   always_comb
   begin
      for (int k = 0; k < 16; k++)
      begin
         id_space[k] = 8'(8'ha0 + k);
      end
   end

   // registered read, top bit selects id space
   always_ff @(posedge clk_i)
   begin
      if (rd_addr_i[21])
      begin
         rd_data_o <= id_space[rd_addr_i[3:0]];
      end
      else
      begin
         rd_data_o <= mem[rd_addr_i[12:0]];
      end
      if (wr_en_i && !wr_addr_i[21])
      begin
         mem[wr_addr_i[12:0]] <= wr_data_i;
      end
   end
endmodule

// ===== src/tpf_top.sv
// table pointer flash self-programming controller with wishbone slave
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module tpf_top #(
   parameter int PROG_CYC = tpf_pkg::PROG_CYCLES,
   parameter int ERASE_CYC = tpf_pkg::ERASE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // core stall during long cycles
   output logic stall_o,
   // full pointer
   output logic [21:0] table_byte_pointer_o
);
   typedef struct packed {
      tpf_pkg::tpf_state_t st;
      logic [21:0] ptr;
      logic [7:0] latch;
      logic erase_sel;
      logic enable;
      logic fault;
      logic start;
      logic [1:0] unlock;
      logic [31:0] rdat;
      logic ack;
      logic stall;
      logic [1:0] act;
      logic [13:0] timer;
      logic [10:0] sweep;
      logic [21:0] base;
      logic booted;
   } tpf_state_s_t;

   tpf_state_s_t q;
   tpf_state_s_t next_q;
   logic [7:0] hold [0:tpf_pkg::HOLD_N-1];
   logic [7:0] mem_rdata;
   logic mem_wr;
   logic [21:0] mem_wr_addr;
   logic [7:0] mem_wr_data;
   logic [21:0] mem_rd_addr;
   logic req;
   logic wr_req;
   logic hold_we;
   logic [21:0] pre_ptr;

   // step the low 21 bits only, keeping the space select bit
   function automatic logic [21:0] step_ptr(input logic [21:0] p, input logic up);
      logic [20:0] low;
      low = up ? 21'(p[20:0] + 21'h1) : 21'(p[20:0] - 21'h1);
      return {p[21], low};
   endfunction

   // true when a byte lane carries the low byte
   function automatic logic lane0(input logic [3:0] s);
      return s[0];
   endfunction

   assign req = cyc_i && stb_i && !q.ack;
   assign wr_req = req && we_i && lane0(sel_i);
   assign hold_we = wr_req && adr_i == tpf_pkg::ADR_TABLE_OP
                    && dat_i[tpf_pkg::OP_WRITE_BIT] && q.st == tpf_pkg::ST_IDLE;
   // pointer one step ahead, used by a pre-increment short write
   assign pre_ptr = step_ptr(q.ptr, 1'b1);

   tpf_mem u_mem (
      .clk_i(clk_i),
      .rd_addr_i(mem_rd_addr),
      .rd_data_o(mem_rdata),
      .wr_en_i(mem_wr),
      .wr_addr_i(mem_wr_addr),
      .wr_data_i(mem_wr_data)
   );

   // holding bytes: loaded by short writes, never cleared after a cycle
   always_ff @(posedge clk_i)
   begin
      if (hold_we)
      begin
         // pre-increment picks the next slot before writing
         if (dat_i[2:1] == tpf_pkg::ACT_PRE_INC)
         begin
            hold[pre_ptr[5:0]] <= q.latch;
         end
         else
         begin
            hold[q.ptr[5:0]] <= q.latch;
         end
      end
   end

   // memory port drive: sweep one byte per cycle during long cycles
   always_comb
   begin
      mem_rd_addr = q.ptr;
      mem_wr = q.st == tpf_pkg::ST_LONG && q.sweep != 11'h7ff;
      mem_wr_addr = 22'h000000;
      mem_wr_data = 8'hff;
      if (q.erase_sel)
      begin
         // whole 1024-byte block, low bits of pointer unused
         mem_wr_addr = {q.base[21:10], q.sweep[9:0]};
      end
      else
      begin
         mem_wr_addr = {q.base[21:6], q.sweep[5:0]};
         mem_wr_data = hold[q.sweep[5:0]];
         mem_wr = mem_wr && q.sweep < 11'd64;
      end
   end

   // next state
   always_comb
   begin
      next_q = q;
      next_q.ack = req;
      next_q.booted = 1'b1;
      if (!q.booted)
      begin
         next_q.fault = 1'b0;
      end
      // register reads, unlock reads zero
      if (req && !we_i)
      begin
         case (adr_i)
            tpf_pkg::ADR_PTR_LOW: next_q.rdat = {24'h000000, q.ptr[7:0]};
            tpf_pkg::ADR_PTR_HIGH: next_q.rdat = {24'h000000, q.ptr[15:8]};
            tpf_pkg::ADR_PTR_UPPER: next_q.rdat = {26'h0000000, q.ptr[21:16]};
            tpf_pkg::ADR_LATCH: next_q.rdat = {24'h000000, q.latch};
            tpf_pkg::ADR_CONTROL: next_q.rdat = {27'h0000000, q.erase_sel, q.fault,
                                                 q.enable, q.start, 1'b0};
            default: next_q.rdat = 32'h00000000;
         endcase
      end
      case (q.st)
         tpf_pkg::ST_IDLE:
         begin
            if (wr_req)
            begin
               // any write other than the next unlock key breaks the pair
               if (adr_i != tpf_pkg::ADR_UNLOCK && adr_i != tpf_pkg::ADR_CONTROL)
               begin
                  next_q.unlock = 2'h0;
               end
               case (adr_i)
                  tpf_pkg::ADR_PTR_LOW: next_q.ptr[7:0] = dat_i[7:0];
                  tpf_pkg::ADR_PTR_HIGH: next_q.ptr[15:8] = dat_i[7:0];
                  tpf_pkg::ADR_PTR_UPPER: next_q.ptr[21:16] = dat_i[5:0];
                  tpf_pkg::ADR_LATCH: next_q.latch = dat_i[7:0];
                  tpf_pkg::ADR_UNLOCK:
                  begin
                     if (dat_i[7:0] == tpf_pkg::KEY_FIRST)
                     begin
                        next_q.unlock = 2'h1;
                     end
                     else if (dat_i[7:0] == tpf_pkg::KEY_SECOND && q.unlock == 2'h1)
                     begin
                        next_q.unlock = 2'h2;
                     end
                     else
                     begin
                        next_q.unlock = 2'h0;
                     end
                  end
                  tpf_pkg::ADR_CONTROL:
                  begin
                     next_q.erase_sel = dat_i[tpf_pkg::CTL_ERASE_BIT];
                     next_q.enable = dat_i[tpf_pkg::CTL_ENABLE_BIT];
                     next_q.fault = dat_i[tpf_pkg::CTL_FAULT_BIT];
                     next_q.unlock = 2'h0;
                     if (dat_i[tpf_pkg::CTL_START_BIT])
                     begin
                        if (q.unlock == 2'h2 && dat_i[tpf_pkg::CTL_ENABLE_BIT])
                        begin
                           // accepted: erase the addressed 1024-byte block or program its addressed 64-byte row
                           next_q.start = 1'b1;
                           next_q.fault = 1'b1; // cleared when the timer expires
                           next_q.st = tpf_pkg::ST_LONG;
                           next_q.stall = 1'b1;
                           next_q.base = q.ptr;
                           next_q.sweep = 11'h000;
                           next_q.timer = dat_i[tpf_pkg::CTL_ERASE_BIT]
                              ? 14'(ERASE_CYC - 1) : 14'(PROG_CYC - 1);
                        end
                        else
                        begin
                           next_q.fault = 1'b1;
                        end
                     end
                  end
                  tpf_pkg::ADR_TABLE_OP:
                  begin
                     next_q.act = dat_i[2:1];
                     if (dat_i[2:1] == tpf_pkg::ACT_PRE_INC)
                     begin
                        next_q.ptr = step_ptr(q.ptr, 1'b1);
                     end
                     if (dat_i[tpf_pkg::OP_WRITE_BIT])
                     begin
                        next_q.st = tpf_pkg::ST_DONE;
                     end
                     else
                     begin
                        next_q.st = tpf_pkg::ST_READ;
                        next_q.stall = 1'b1;
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         tpf_pkg::ST_READ:
         begin
            // memory read data registered this cycle, take it next
            next_q.st = tpf_pkg::ST_DONE;
         end
         tpf_pkg::ST_DONE:
         begin
            if (q.stall)
            begin
               next_q.latch = mem_rdata;
            end
            next_q.stall = 1'b0;
            case (q.act)
               tpf_pkg::ACT_POST_INC: next_q.ptr = step_ptr(q.ptr, 1'b1);
               tpf_pkg::ACT_POST_DEC: next_q.ptr = step_ptr(q.ptr, 1'b0);
               default: next_q.ptr = q.ptr;
            endcase
            next_q.st = tpf_pkg::ST_IDLE;
         end
         tpf_pkg::ST_LONG:
         begin
            if (q.sweep != 11'h7ff && q.sweep != 11'h3ff)
            begin
               next_q.sweep = 11'(q.sweep + 11'h1);
            end
            else
            begin
               next_q.sweep = 11'h7ff;
            end
            if (q.timer == 14'h0000)
            begin
               // timer expiry ends the cycle
               next_q.st = tpf_pkg::ST_IDLE;
               next_q.start = 1'b0;
               next_q.fault = 1'b0;
               next_q.stall = 1'b0;
               next_q.erase_sel = 1'b0;
            end
            else
            begin
               next_q.timer = 14'(q.timer - 14'h1);
            end
         end
         default: next_q.st = tpf_pkg::ST_IDLE;
      endcase
   end

   // state register; a reset mid-cycle leaves the fault flag set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q.st <= tpf_pkg::ST_IDLE;
         q.ptr <= tpf_pkg::PTR_RST;
         q.latch <= tpf_pkg::LATCH_RST;
         q.erase_sel <= 1'b0;
         q.enable <= 1'b0;
         q.fault <= q.start;
         q.start <= 1'b0;
         q.unlock <= 2'h0;
         q.rdat <= 32'h00000000;
         q.ack <= 1'b0;
         q.stall <= 1'b0;
         q.act <= tpf_pkg::ACT_KEEP;
         q.timer <= 14'h0000;
         q.sweep <= 11'h7ff;
         q.base <= tpf_pkg::PTR_RST;
         q.booted <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // outputs straight from flip-flops
   assign dat_o = q.rdat;
   assign ack_o = q.ack;
   assign stall_o = q.stall;
   assign table_byte_pointer_o = q.ptr;
endmodule

// ===== test/tpf_assertions.sv
// port checker for the table pointer flash block
`timescale 1ns/1ns
module tpf_assertions #(
   parameter int PROG_CYC = 70,
   parameter int ERASE_CYC = 1100
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // stall and pointer
   input wire logic stall_o,
   input wire logic [21:0] table_byte_pointer_o
);
   typedef struct packed {
      logic [15:0] run;
      logic [1:0] key;
   } tpf_chk_t;
   tpf_chk_t st;
   tpf_chk_t next_st;
   logic wr_take;
   logic rd_take;
   logic up_take;
   logic unlocked;
   // requests the block really accepts
   assign wr_take = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && !stall_o;
   assign rd_take = cyc_i && stb_i && !ack_o && !we_i;
   assign up_take = wr_take && adr_i == tpf_pkg::ADR_PTR_UPPER;
   assign unlocked = st.key == 2'h2;
   // stall run length and unlock pair progress
   always_comb
   begin
      next_st = st;
      next_st.run = stall_o ? st.run + 16'h1 : 16'h0;
      if (wr_take && adr_i != tpf_pkg::ADR_UNLOCK)
         next_st.key = 2'h0;
      else if (wr_take && dat_i[7:0] == tpf_pkg::KEY_FIRST)
         next_st.key = 2'h1;
      else if (wr_take)
         next_st.key = (dat_i[7:0] == tpf_pkg::KEY_SECOND && st.key == 2'h1) ? 2'h2 : 2'h0;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st <= '0;
      else
         st <= next_st;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_one_pulse:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack is not one pulse a cycle after the request");
   chk_ptr_low_byte:
      assert property (wr_take && adr_i == tpf_pkg::ADR_PTR_LOW
         |=> table_byte_pointer_o[7:0] == $past(dat_i[7:0]))
      else $error("pointer low byte not loaded");
   chk_ptr_upper_bits:
      assert property (up_take |=> table_byte_pointer_o[21:16] == $past(dat_i[5:0]))
      else $error("pointer upper bits not loaded");
   chk_top_bit_kept:
      assert property ($changed(table_byte_pointer_o[21]) |-> $past(up_take))
      else $error("pointer top bit moved without an upper byte write");
   chk_unlock_reads_zero:
      assert property (rd_take && adr_i == tpf_pkg::ADR_UNLOCK |=> dat_o == 32'h0)
      else $error("unlock register read not zero");
   chk_start_unlock:
      assert property (wr_take && adr_i == tpf_pkg::ADR_CONTROL && dat_i[1] && dat_i[2]
         |=> stall_o == $past(unlocked))
      else $error("long cycle start does not follow the unlock pair");
   chk_read_stall:
      assert property (wr_take && adr_i == tpf_pkg::ADR_TABLE_OP && !dat_i[0]
         |=> stall_o [*2] ##1 !stall_o)
      else $error("table read stall not two cycles");
   chk_stall_bounded:
      assert property (stall_o |-> st.run <= 16'(ERASE_CYC + 2))
      else $error("stall outlasts the longest timed cycle");
   chk_long_length:
      assert property ($fell(stall_o) |-> st.run <= 16'd4 || st.run >= 16'(PROG_CYC))
      else $error("long cycle ended early");
   // main scenarios
   cov_long: cover property ($fell(stall_o) && st.run > 16'd50);
   cov_start: cover property (wr_take && adr_i == tpf_pkg::ADR_CONTROL && unlocked);
   cov_unlock_rd: cover property (rd_take && adr_i == tpf_pkg::ADR_UNLOCK);
endmodule
bind tpf_top tpf_assertions #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .cyc_i(cyc_i),
   .stb_i(stb_i),
   .we_i(we_i),
   .adr_i(adr_i),
   .sel_i(sel_i),
   .dat_i(dat_i),
   .dat_o(dat_o),
   .ack_o(ack_o),
   .stall_o(stall_o),
   .table_byte_pointer_o(table_byte_pointer_o)
);

// ===== test/tpf_core_model.sv
// processor core model issuing classic wishbone cycles
`timescale 1ns/1ns
module tpf_core_model (
   // clock
   input wire logic clk_i,
   // wishbone master
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic ack_i,
   // core stall
   input wire logic stall_i
);
   // idle bus at time zero
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // one cycle held until ack is sampled; a stalled core issues nothing
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic [3:0] s);
      logic [31:0] word;
      // unused upper data bits and upper lanes carry random values
      word = {24'($urandom), d};
      @(posedge clk_i);
      while (stall_i !== 1'b0) @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= {3'($urandom), s[0]};
      dat_o <= word;
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= ~w;
      adr_o <= ~a;
      dat_o <= ~word;
   endtask
   // unlock pair directly before the start write, nothing in between
   task automatic start_long(input logic [7:0] ctl);
      xfer(1'b1, tpf_pkg::ADR_UNLOCK, tpf_pkg::KEY_FIRST, 4'hf);
      xfer(1'b1, tpf_pkg::ADR_UNLOCK, tpf_pkg::KEY_SECOND, 4'hf);
      xfer(1'b1, tpf_pkg::ADR_CONTROL, ctl, 4'hf);
   endtask
endmodule

// ===== test/tpf_top_tb.sv
// self-checking bench for the table pointer flash block
`timescale 1ns/1ns
module tpf_top_tb;
   localparam logic [21:0] ST_P [4] = '{22'h3fffff, 22'h3fffff, 22'h200000, 22'h1fffff};
   localparam logic [21:0] EX_P [4] = '{22'h3fffff, 22'h200000, 22'h3fffff, 22'h000000};
   logic clk_i;
   logic rst_i;
   logic cyc_i;
   logic stb_i;
   logic we_i;
   logic [3:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic ack_o;
   logic stall_o;
   logic [21:0] ptr;
   logic [15:0] notes[$];
   logic [15:0] note;
   logic [7:0] d[64];
   logic [21:0] p;
   int error_cnt;
   int n_checks;
   int cycles;
   tpf_top #(.PROG_CYC(70), .ERASE_CYC(1100)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .stall_o(stall_o),
      .table_byte_pointer_o(ptr));
   tpf_core_model core (.clk_i(clk_i), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
      .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .ack_i(ack_o), .stall_i(stall_o));
   // verdict and end of run
   task automatic summarize();
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] s);
      n_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      core.xfer(1'b1, a, v, 4'hf);
   endtask
   // note the expected byte, then read
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      notes.push_back({e, m});
      core.xfer(1'b0, a, 8'($urandom), 4'hf);
   endtask
   // let stall end and the pointer update land
   task automatic settle();
      @(posedge clk_i);
      while (stall_o !== 1'b0) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
   endtask
   task automatic setp(input logic [21:0] v);
      wr(tpf_pkg::ADR_PTR_LOW, v[7:0]);
      wr(tpf_pkg::ADR_PTR_HIGH, v[15:8]);
      wr(tpf_pkg::ADR_PTR_UPPER, {2'h0, v[21:16]});
      settle();
   endtask
   task automatic tbl(input logic [1:0] act, input logic w);
      wr(tpf_pkg::ADR_TABLE_OP, {5'h0, act, w});
      settle();
   endtask
   task automatic rd_bytes(input logic [21:0] base, input int n);
      setp(base);
      for (int k = 0; k < n; k++)
      begin
         tbl(tpf_pkg::ACT_POST_INC, 1'b0);
         rd(tpf_pkg::ADR_LATCH, d[k], 8'hff);
      end
   endtask
   // clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // read results against the oldest note
   always @(posedge clk_i)
   begin
      if (ack_o === 1'b1 && we_i === 1'b0)
      begin
         note = notes.pop_front();
         chk("read data", {14'h0, note[15:8] & note[7:0]}, {14'h0, dat_o[7:0] & note[7:0]});
      end
   end
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end
   initial
   begin
      rst_i = 1'b1;
      void'($urandom(32'hc32d23fa));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(tpf_pkg::ADR_CONTROL, 8'h00, 8'hff);
      rd(tpf_pkg::ADR_UNLOCK, 8'h00, 8'hff);
      rd(4'h9, 8'h00, 8'hff);
      p = 22'($urandom);
      setp(p);
      chk("pointer", p, ptr);
      core.xfer(1'b1, tpf_pkg::ADR_PTR_LOW, ~p[7:0], 4'he);
      settle();
      chk("pointer lane off", p, ptr);
      for (int i = 0; i < 4; i++)
      begin
         setp(ST_P[i]);
         tbl(2'(i), 1'b0);
         chk("pointer action", EX_P[i], ptr);
      end
      setp(22'h200000);
      tbl(tpf_pkg::ACT_POST_INC, 1'b0);
      rd(tpf_pkg::ADR_LATCH, 8'ha0, 8'hff);
      setp(22'h000400);
      for (int i = 0; i < 64; i++)
      begin
         d[i] = 8'($urandom);
         wr(tpf_pkg::ADR_LATCH, d[i]);
         tbl(tpf_pkg::ACT_POST_INC, 1'b1);
      end
      chk("pointer", 22'h000440, ptr);
      wr(tpf_pkg::ADR_UNLOCK, tpf_pkg::KEY_FIRST);
      wr(tpf_pkg::ADR_LATCH, d[0]);
      wr(tpf_pkg::ADR_UNLOCK, tpf_pkg::KEY_SECOND);
      wr(tpf_pkg::ADR_CONTROL, 8'h06);
      rd(tpf_pkg::ADR_CONTROL, 8'h0c, 8'hff);
      core.start_long(8'h02);
      rd(tpf_pkg::ADR_CONTROL, 8'h08, 8'hff);
      setp(22'h00042a);
      core.start_long(8'h06);
      rd(tpf_pkg::ADR_CONTROL, 8'h04, 8'hff);
      rd_bytes(22'h000400, 64);
      setp(22'h000805);
      core.start_long(8'h06);
      rd_bytes(22'h000800, 4);
      setp(22'h0007ff);
      core.start_long(8'h16);
      rd(tpf_pkg::ADR_CONTROL, 8'h04, 8'hff);
      rd_bytes(22'h000800, 4);
      // the erased block reads all ones at both of its ends
      setp(22'h000400);
      tbl(tpf_pkg::ACT_KEEP, 1'b0);
      rd(tpf_pkg::ADR_LATCH, 8'hff, 8'hff);
      setp(22'h0007ff);
      tbl(tpf_pkg::ACT_KEEP, 1'b0);
      rd(tpf_pkg::ADR_LATCH, 8'hff, 8'hff);
      // program the first 64-byte row of the freshly erased block, then cut the cycle by reset
      setp(22'h000400);
      core.start_long(8'h06);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rd(tpf_pkg::ADR_CONTROL, 8'h08, 8'hff);
      settle();
      chk("pointer after reset", 22'h0, ptr);
      summarize();
   end
endmodule
